// ### lcd_cfg_pkg.sv
// Notes on behaviour
// - Frame division from four-bit prescale field
// - One enable bit per segment pin
// - Control holds multiplex, timing source, sleep
// - Panel runs only with module enable set
// - One stored bit per pixel, grouped per common
// - Clock select zero turns regulator off
// - Charge pump bit, picks mode two/three (clock off) or zero/one (clock on)
// - Bias voltage from three-bit field
// - Mode select bit for regulator bias
// - Regulator clock from two-bit select
// - Frame flag, enable, priority at bit six
// - Unimplemented bits read as zero
// - Refused pixel write sets write error
// - Frame interrupt only multiplexed second shape
// - Sleep stop halts, drives minimum voltage
package lcd_cfg_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register map
  localparam logic [5:0] ADDR_PANEL     = 6'h00;
  localparam logic [5:0] ADDR_PRESCALE  = 6'h01;
  localparam logic [5:0] ADDR_REGULATOR = 6'h02;
  localparam logic [5:0] ADDR_SEG_FIRST = 6'h03;
  localparam logic [5:0] ADDR_SEG_LAST  = 6'h07;
  localparam logic [5:0] ADDR_PIX_FIRST = 6'h08;
  localparam logic [5:0] ADDR_PIX_LAST  = 6'h1F;
  localparam logic [5:0] ADDR_FLAG      = 6'h20;
  localparam logic [5:0] ADDR_ENABLE    = 6'h21;
  localparam logic [5:0] ADDR_PRIORITY  = 6'h22;

  // Readable bit masks
  localparam logic [7:0] MASK_PANEL     = 8'hEF;
  localparam logic [7:0] MASK_PRESCALE  = 8'hFF;
  localparam logic [7:0] MASK_PRE_WR    = 8'hCF;
  localparam logic [7:0] MASK_REGULATOR = 8'h7F;
  localparam logic [7:0] MASK_FULL      = 8'hFF;
  localparam logic [7:0] MASK_TOP_SEG   = 8'h01;
  localparam logic [7:0] MASK_NONE      = 8'h00;
  localparam logic [7:0] MASK_IRQ       = 8'h40;

  localparam int FRAME_IRQ_BIT  = 6;
  localparam int SEG_REGS       = 5;
  localparam int PIX_REGS       = 24;
  localparam int PIX_PER_COM    = 6;
  localparam int COMMONS        = 4;
  localparam int SEGMENTS       = 33;
  localparam int FRAME_CNT_W    = 7;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] SRC_SYSTEM = 2'h0;
  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] CLK_OFF    = 2'h0;

  // Bias configuration codes (mode number)
  localparam logic [1:0] BIAS_M0 = 2'h0;
  localparam logic [1:0] BIAS_M1 = 2'h1;
  localparam logic [1:0] BIAS_M2 = 2'h2;
  localparam logic [1:0] BIAS_M3 = 2'h3;

  typedef struct packed {
    logic       module_enable;
    logic       sleep_stop_enable;
    logic       pixel_write_error;
    logic       rsv4;
    logic [1:0] timing_source;
    logic [1:0] multiplex_select;
  } panel_control_t;

  typedef struct packed {
    logic       drive_shape_select;
    logic       half_third_select;
    logic       module_active;
    logic       pixel_write_allowed;
    logic [3:0] frame_prescale;
  } prescale_t;

  typedef struct packed {
    logic       rsv7;
    logic       charge_pump_enable;
    logic [2:0] bias_voltage;
    logic       bias_mode_select;
    logic [1:0] regulator_clock_select;
  } regulator_t;

  typedef struct packed {
    logic       regulator_on;
    logic [1:0] bias_config;
  } bias_state_t;

endpackage

// ### frame_timer.sv
`timescale 1ns/1ns
module frame_timer #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Control
  input  wire logic             run_in,
  input  wire logic             tick_in,
  input  wire logic [CNT_W-1:0] period_in,
  // Event
  output logic                  frame_end_out
);

  logic [CNT_W-1:0] count_q;

  // Counts source ticks; one frame is period_in ticks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q       <= '0;
      frame_end_out <= 1'b0;
    end else if (!run_in) begin
      count_q       <= '0;
      frame_end_out <= 1'b0;
    end else if (tick_in) begin
      if (count_q >= CNT_W'(period_in - 1'b1)) begin
        count_q       <= '0;
        frame_end_out <= 1'b1;
      end else begin
        count_q       <= CNT_W'(count_q + 1'b1);
        frame_end_out <= 1'b0;
      end
    end else begin
      frame_end_out <= 1'b0;
    end
  end

endmodule // frame_timer

// ### segment_lcd_config_regs.sv
`timescale 1ns/1ns
module segment_lcd_config_regs #(
  parameter int ADDR_W = lcd_cfg_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                              clk_in,
  input  wire logic                              rst_in,
  // Register port
  input  wire logic [ADDR_W-1:0]                 addr_in,
  input  wire logic [7:0]                        wdata_in,
  input  wire logic                              wr_in,
  input  wire logic                              rd_in,
  output logic [7:0]                             rdata_out,
  // Device state and timing sources
  input  wire logic                              sleep_in,
  input  wire logic [2:0]                        timing_tick_in,
  // Configuration towards the drivers
  output lcd_cfg_pkg::panel_control_t            panel_out,
  output lcd_cfg_pkg::prescale_t                 prescale_out,
  output lcd_cfg_pkg::regulator_t                regulator_out,
  output lcd_cfg_pkg::bias_state_t               bias_out,
  output logic [lcd_cfg_pkg::SEGMENTS-1:0]       seg_enable_out,
  output logic [lcd_cfg_pkg::COMMONS*lcd_cfg_pkg::SEGMENTS-1:0] pixel_out,
  output logic                                   drive_min_out,
  output logic                                   frame_end_out,
  // Interrupt
  output logic                                   irq_out,
  output logic                                   frame_irq_priority_out
);

  lcd_cfg_pkg::panel_control_t panel_q;
  lcd_cfg_pkg::prescale_t      prescale_q;
  lcd_cfg_pkg::regulator_t     regulator_q;
  lcd_cfg_pkg::bias_state_t    bias_q;
  logic [7:0]                  seg_q [lcd_cfg_pkg::SEG_REGS];
  logic [7:0]                  pix_q [lcd_cfg_pkg::PIX_REGS];
  logic [7:0]                  flag_q;
  logic [7:0]                  enable_q;
  logic [7:0]                  priority_q;
  logic                        parity_q;
  logic                        drive_min_q;
  logic                        irq_q;
  logic [7:0]                  rdata_q;

  logic                        wr_panel;
  logic                        wr_prescale;
  logic                        wr_regulator;
  logic                        wr_flag;
  logic                        wr_pix_any;
  logic                        pix_refused;
  logic [4:0]                  pix_idx;
  logic [2:0]                  seg_idx;
  logic                        stopped;
  logic                        running;
  logic                        shape_b_mux;
  logic                        frame_end;
  logic                        frame_event;
  logic                        tick;
  logic [2:0]                  factor;
  logic [lcd_cfg_pkg::FRAME_CNT_W-1:0] period;

  function automatic logic [7:0] pix_mask(input logic [4:0] idx);
    logic [4:0] slot;
    slot = 5'(idx % 5'(lcd_cfg_pkg::PIX_PER_COM));
    if (slot == 5'h04) begin
      pix_mask = lcd_cfg_pkg::MASK_TOP_SEG;
    end else if (slot == 5'h05) begin
      pix_mask = lcd_cfg_pkg::MASK_NONE;
    end else begin
      pix_mask = lcd_cfg_pkg::MASK_FULL;
    end
  endfunction

  assign wr_panel     = wr_in && (addr_in == lcd_cfg_pkg::ADDR_PANEL);
  assign wr_prescale  = wr_in && (addr_in == lcd_cfg_pkg::ADDR_PRESCALE);
  assign wr_regulator = wr_in && (addr_in == lcd_cfg_pkg::ADDR_REGULATOR);
  assign wr_flag      = wr_in && (addr_in == lcd_cfg_pkg::ADDR_FLAG);
  assign wr_pix_any   = wr_in && (addr_in >= lcd_cfg_pkg::ADDR_PIX_FIRST) &&
                        (addr_in <= lcd_cfg_pkg::ADDR_PIX_LAST);
  assign pix_idx      = 5'(addr_in - lcd_cfg_pkg::ADDR_PIX_FIRST);
  assign seg_idx      = 3'(addr_in - lcd_cfg_pkg::ADDR_SEG_FIRST);
  assign pix_refused  = wr_pix_any && !prescale_q.pixel_write_allowed;

  // System clock source stops on sleep whatever the sleep bit says
  assign stopped     = sleep_in && (panel_q.sleep_stop_enable ||
                       panel_q.timing_source == lcd_cfg_pkg::SRC_SYSTEM);
  assign running     = panel_q.module_enable && !stopped;
  assign shape_b_mux = prescale_q.drive_shape_select &&
                       (panel_q.multiplex_select != lcd_cfg_pkg::MUX_STATIC);
  // Second shape needs two frames to cancel DC, so only every second frame ends a phase
  assign frame_event = frame_end && shape_b_mux && parity_q;

  // Timing source select: 0 is the system clock, others are tick inputs
  always_comb begin
    tick = 1'b1;
    case (panel_q.timing_source)
      2'h1:    tick = timing_tick_in[0];
      2'h2:    tick = timing_tick_in[1];
      2'h3:    tick = timing_tick_in[2];
      default: tick = 1'b1;
    endcase
  end

  // Ticks per frame = factor x (prescale + 1)
  always_comb begin
    factor = 3'h4;
    case (panel_q.multiplex_select)
      2'h2:    factor = 3'h3;
      default: factor = 3'h4;
    endcase
    // Widen before the product: four times sixteen overflows five bits
    period = lcd_cfg_pkg::FRAME_CNT_W'(factor) *
             (lcd_cfg_pkg::FRAME_CNT_W'(prescale_q.frame_prescale) + lcd_cfg_pkg::FRAME_CNT_W'(1));
  end

  frame_timer #(
    .CNT_W (lcd_cfg_pkg::FRAME_CNT_W)
  ) u_frame_timer (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .run_in        (running),
    .tick_in       (tick),
    .period_in     (period),
    .frame_end_out (frame_end)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      panel_q <= lcd_cfg_pkg::RESET_BYTE;
    end else begin
      if (wr_panel) begin
        panel_q <= wdata_in & lcd_cfg_pkg::MASK_PANEL;
      end
      // Set beats a same-cycle software clear
      if (pix_refused) begin
        panel_q.pixel_write_error <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_q <= lcd_cfg_pkg::RESET_BYTE;
    end else begin
      if (wr_prescale) begin
        prescale_q.drive_shape_select <= wdata_in[7];
        prescale_q.half_third_select  <= wdata_in[6];
        prescale_q.frame_prescale     <= wdata_in[3:0];
      end
      prescale_q.module_active <= running;
      // Writes open on the frame event and close at the next frame edge
      if (stopped) begin
        prescale_q.pixel_write_allowed <= 1'b0;
      end else if (!panel_q.module_enable || !shape_b_mux) begin
        prescale_q.pixel_write_allowed <= 1'b1;
      end else if (frame_event) begin
        prescale_q.pixel_write_allowed <= 1'b1;
      end else if (frame_end) begin
        prescale_q.pixel_write_allowed <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      parity_q <= 1'b0;
    end else if (!running) begin
      parity_q <= 1'b0;
    end else if (frame_end) begin
      parity_q <= !parity_q;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      regulator_q <= lcd_cfg_pkg::RESET_BYTE;
      bias_q      <= '0;
    end else if (wr_regulator) begin
      regulator_q <= wdata_in & lcd_cfg_pkg::MASK_REGULATOR;
      bias_q.regulator_on <= (wdata_in[1:0] != lcd_cfg_pkg::CLK_OFF);
      if (wdata_in[1:0] == lcd_cfg_pkg::CLK_OFF) begin
        bias_q.bias_config <= wdata_in[6] ? lcd_cfg_pkg::BIAS_M2 : lcd_cfg_pkg::BIAS_M3;
      end else begin
        bias_q.bias_config <= wdata_in[6] ? lcd_cfg_pkg::BIAS_M0 : lcd_cfg_pkg::BIAS_M1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < lcd_cfg_pkg::SEG_REGS; gi++) begin : g_seg_reg
      localparam logic [7:0] M = (gi == lcd_cfg_pkg::SEG_REGS - 1) ?
                                 lcd_cfg_pkg::MASK_TOP_SEG : lcd_cfg_pkg::MASK_FULL;
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          seg_q[gi] <= lcd_cfg_pkg::RESET_BYTE;
        end else if (wr_in && addr_in >= lcd_cfg_pkg::ADDR_SEG_FIRST &&
                     addr_in <= lcd_cfg_pkg::ADDR_SEG_LAST && seg_idx == 3'(gi)) begin
          seg_q[gi] <= wdata_in & M;
        end
      end
    end
    for (gi = 0; gi < lcd_cfg_pkg::PIX_REGS; gi++) begin : g_pix_reg
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pix_q[gi] <= lcd_cfg_pkg::RESET_BYTE;
        end else if (wr_pix_any && !pix_refused && pix_idx == 5'(gi)) begin
          pix_q[gi] <= wdata_in & pix_mask(5'(gi));
        end
      end
    end
    for (gi = 0; gi < lcd_cfg_pkg::SEGMENTS; gi++) begin : g_seg_map
      assign seg_enable_out[gi] = seg_q[gi / 8][gi % 8];
      for (genvar k = 0; k < lcd_cfg_pkg::COMMONS; k++) begin : g_com
        assign pixel_out[k * lcd_cfg_pkg::SEGMENTS + gi] =
          pix_q[k * lcd_cfg_pkg::PIX_PER_COM + gi / 8][gi % 8];
      end
    end
  endgenerate

  // Status flag: write one clears, hardware set wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_q     <= lcd_cfg_pkg::RESET_BYTE;
      enable_q   <= lcd_cfg_pkg::RESET_BYTE;
      priority_q <= lcd_cfg_pkg::RESET_BYTE;
    end else begin
      if (frame_event) begin
        flag_q[lcd_cfg_pkg::FRAME_IRQ_BIT] <= 1'b1;
      end else if (wr_flag && wdata_in[lcd_cfg_pkg::FRAME_IRQ_BIT]) begin
        flag_q[lcd_cfg_pkg::FRAME_IRQ_BIT] <= 1'b0;
      end
      if (wr_in && addr_in == lcd_cfg_pkg::ADDR_ENABLE) begin
        enable_q <= wdata_in & lcd_cfg_pkg::MASK_IRQ;
      end
      if (wr_in && addr_in == lcd_cfg_pkg::ADDR_PRIORITY) begin
        priority_q <= wdata_in & lcd_cfg_pkg::MASK_IRQ;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_q       <= 1'b0;
      drive_min_q <= 1'b0;
    end else begin
      irq_q       <= |(flag_q & enable_q);
      drive_min_q <= stopped;
    end
  end

  // Read data in the cycle after the strobe only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= lcd_cfg_pkg::RESET_BYTE;
    end else if (!rd_in) begin
      rdata_q <= lcd_cfg_pkg::RESET_BYTE;
    end else if (addr_in >= lcd_cfg_pkg::ADDR_PIX_FIRST && addr_in <= lcd_cfg_pkg::ADDR_PIX_LAST) begin
      rdata_q <= pix_q[pix_idx] & pix_mask(pix_idx);
    end else if (addr_in >= lcd_cfg_pkg::ADDR_SEG_FIRST && addr_in <= lcd_cfg_pkg::ADDR_SEG_LAST) begin
      rdata_q <= seg_q[seg_idx];
    end else begin
      case (addr_in)
        lcd_cfg_pkg::ADDR_PANEL:     rdata_q <= panel_q & lcd_cfg_pkg::MASK_PANEL;
        lcd_cfg_pkg::ADDR_PRESCALE:  rdata_q <= prescale_q;
        lcd_cfg_pkg::ADDR_REGULATOR: rdata_q <= regulator_q & lcd_cfg_pkg::MASK_REGULATOR;
        lcd_cfg_pkg::ADDR_FLAG:      rdata_q <= flag_q & lcd_cfg_pkg::MASK_IRQ;
        lcd_cfg_pkg::ADDR_ENABLE:    rdata_q <= enable_q;
        lcd_cfg_pkg::ADDR_PRIORITY:  rdata_q <= priority_q;
        default:                     rdata_q <= lcd_cfg_pkg::RESET_BYTE;
      endcase
    end
  end

  assign rdata_out              = rdata_q;
  assign panel_out              = panel_q;
  assign prescale_out           = prescale_q;
  assign regulator_out          = regulator_q;
  assign bias_out               = bias_q;
  assign drive_min_out          = drive_min_q;
  assign frame_end_out          = frame_end;
  assign irq_out                = irq_q;
  assign frame_irq_priority_out = priority_q[lcd_cfg_pkg::FRAME_IRQ_BIT];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_prescale_write;
    wr_prescale |=> prescale_q.frame_prescale == $past(wdata_in[3:0]);
  endproperty
  a_prescale_write: assert property (p_prescale_write) else $error("prescale field not stored");

  property p_active_needs_enable;
    prescale_q.module_active |-> $past(panel_q.module_enable) && !$past(stopped);
  endproperty
  a_active_needs_enable: assert property (p_active_needs_enable) else $error("active without enable");

  property p_regulator_off;
    wr_regulator && wdata_in[1:0] == 2'h0 |=> !bias_q.regulator_on &&
      bias_q.bias_config == ($past(wdata_in[6]) ? 2'h2 : 2'h3);
  endproperty
  a_regulator_off: assert property (p_regulator_off) else $error("regulator off mode wrong");

  property p_regulator_on;
    wr_regulator && wdata_in[1:0] != 2'h0 |=> bias_q.regulator_on &&
      bias_q.bias_config == ($past(wdata_in[6]) ? 2'h0 : 2'h1);
  endproperty
  a_regulator_on: assert property (p_regulator_on) else $error("regulator on mode wrong");

  property p_flag_cause;
    $rose(flag_q[6]) |-> $past(shape_b_mux) && $past(frame_end) && $past(parity_q);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("frame flag without cause");

  property p_refused_write;
    pix_refused |=> panel_q.pixel_write_error && pix_q[$past(pix_idx)] == $past(pix_q[pix_idx]);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("refused write not flagged");

  property p_sleep_stop;
    sleep_in && panel_q.sleep_stop_enable |=> drive_min_q && !prescale_q.module_active;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("sleep stop not taken");

  property p_hole_reads_zero;
    rd_in && (addr_in == 6'h0D || addr_in == 6'h23) |=> rdata_q == 8'h00;
  endproperty
  a_hole_reads_zero: assert property (p_hole_reads_zero) else $error("unimplemented read not zero");

  property p_pixel_map;
    wr_pix_any && !pix_refused && pix_idx == 5'h06 |=> pixel_out[40:33] == $past(wdata_in);
  endproperty
  a_pixel_map: assert property (p_pixel_map) else $error("common one pixel map wrong");

  property p_irq_level;
    ##1 irq_q == $past(flag_q[6] && enable_q[6]);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_seg_top;
    wr_in && addr_in == 6'h07 |=> seg_q[4] == ($past(wdata_in) & 8'h01);
  endproperty
  a_seg_top: assert property (p_seg_top) else $error("top segment register wrong");

  c_frame_irq: cover property (frame_event);
  c_write_error: cover property (pix_refused);
  c_sleep_stop: cover property ($rose(drive_min_q));

endmodule // segment_lcd_config_regs

// ### lcd_glass_model.sv
`timescale 1ns/1ns
module lcd_glass_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Panel drive seen by the glass
  input  wire logic        frame_end_in,
  input  wire logic        drive_min_in,
  // Observation
  output logic [15:0]      frames_out
);
  // Glass only sees frames while real waveforms are driven
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frames_out <= 16'h0000;
    end else if (frame_end_in && !drive_min_in) begin
      frames_out <= frames_out + 16'h0001;
    end
  end
endmodule // lcd_glass_model

// ### segment_lcd_config_regs_tb_top.sv
`timescale 1ns/1ns
module segment_lcd_config_regs_tb_top;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;

  logic         clk_in;
  logic         rst_in;
  logic [5:0]   addr_in;
  logic [7:0]   wdata_in;
  logic         wr_in;
  logic         rd_in;
  logic [7:0]   rdata_out;
  logic         sleep_in;
  logic [2:0]   timing_tick_in;
  lcd_cfg_pkg::panel_control_t panel_out;
  lcd_cfg_pkg::prescale_t      prescale_out;
  lcd_cfg_pkg::regulator_t     regulator_out;
  lcd_cfg_pkg::bias_state_t    bias_out;
  logic [32:0]  seg_enable_out;
  logic [131:0] pixel_out;
  logic         drive_min_out;
  logic         frame_end_out;
  logic         irq_out;
  logic         frame_irq_priority_out;
  logic [15:0]  frames;
  int           failures;
  int           tests_run;
  int           cycles;
  int           n;
  logic [7:0]   v;

  // Reserved bits masked, read-only bits fixed, unmapped reads zero
  row_t rows [12] = '{
    '{6'h00, 8'h5F, 8'h4F}, '{6'h01, 8'hFF, 8'hDF}, '{6'h02, 8'hFF, 8'h7F},
    '{6'h03, 8'hA5, 8'hA5}, '{6'h07, 8'hFF, 8'h01}, '{6'h08, 8'h3C, 8'h3C},
    '{6'h0C, 8'hFF, 8'h01}, '{6'h0D, 8'hFF, 8'h00}, '{6'h20, 8'hFF, 8'h00},
    '{6'h21, 8'hFF, 8'h40}, '{6'h22, 8'hFF, 8'h40}, '{6'h30, 8'hFF, 8'h00}};

  segment_lcd_config_regs dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sleep_in(sleep_in),
    .timing_tick_in(timing_tick_in), .panel_out(panel_out), .prescale_out(prescale_out),
    .regulator_out(regulator_out), .bias_out(bias_out), .seg_enable_out(seg_enable_out),
    .pixel_out(pixel_out), .drive_min_out(drive_min_out), .frame_end_out(frame_end_out),
    .irq_out(irq_out), .frame_irq_priority_out(frame_irq_priority_out));

  lcd_glass_model glass_u (
    .clk_in(clk_in), .rst_in(rst_in), .frame_end_in(frame_end_out),
    .drive_min_in(drive_min_out), .frames_out(frames));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
    // Let the written register settle before callers look at outputs
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic wait_frame();
    for (n = 0; n < 100; n++) begin
      @(posedge clk_in);
      #1;
      if (frame_end_out === 1'b1) break;
    end
  endtask

  initial begin
    failures = 0;
    tests_run = 0;
    cycles = 0;
    rst_in = 1'b1;
    addr_in = 6'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    sleep_in = 1'b0;
    timing_tick_in = 3'h0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(6'h00, v); chk_byte(v, 8'h00);
    rd(6'h01, v); chk_byte(v, 8'h10);
    rd(6'h02, v); chk_byte(v, 8'h00);
    rd(6'h14, v); chk_byte(v, 8'h00);
    chk_bit(irq_out, 1'b0);
    chk_byte(frames[7:0], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v); chk_byte(v, rows[i].e);
    end
    chk_byte(seg_enable_out[7:0], 8'hA5);
    chk_bit(seg_enable_out[32], 1'b1);
    chk_bit(frame_irq_priority_out, 1'b1);
    wr(6'h0F, 8'h81);
    chk_bit(pixel_out[41], 1'b1);
    chk_bit(pixel_out[48], 1'b1);
    wr(6'h02, 8'h40); chk_byte({5'h00, bias_out}, {5'h00, 1'b0, lcd_cfg_pkg::BIAS_M2});
    wr(6'h02, 8'h00); chk_byte({5'h00, bias_out}, {5'h00, 1'b0, lcd_cfg_pkg::BIAS_M3});
    wr(6'h02, 8'h6E); chk_byte(regulator_out, 8'h6E);
    chk_byte({5'h00, bias_out}, {5'h00, 1'b1, lcd_cfg_pkg::BIAS_M0});
    wr(6'h02, 8'h01); chk_byte({5'h00, bias_out}, {5'h00, 1'b1, lcd_cfg_pkg::BIAS_M1});
    chk_byte(frames[7:0], 8'h00);
    // Setup order: prescale, segments, control, pixels, regulator, flag, enable
    wr(6'h01, 8'h80);
    wr(6'h03, 8'hFF);
    wr(6'h00, 8'h01);
    wr(6'h08, 8'h11);
    wr(6'h02, 8'h00);
    wr(6'h20, 8'h40);
    wr(6'h21, 8'h40);
    wr(6'h00, 8'h81);
    chk_byte({4'h0, prescale_out.frame_prescale}, 8'h00);
    // Odd frame end closes the write window
    wait_frame();
    chk_bit(prescale_out.module_active, 1'b1);
    wr(6'h08, 8'hEE);
    rd(6'h00, v); chk_byte(v, 8'hA1);
    chk_byte(panel_out, 8'hA1);
    rd(6'h08, v); chk_byte(v, 8'h11);
    for (n = 0; n < 40 && irq_out !== 1'b1; n++) @(posedge clk_in);
    #1;
    chk_bit(irq_out, 1'b1);
    rd(6'h20, v); chk_byte(v, 8'h40);
    chk_bit(frames > 16'h0001, 1'b1);
    // Half multiplex, prescale zero: four ticks from one frame end to the next
    wait_frame();
    wait_frame(); chk_byte(8'(n), 8'h03);
    wr(6'h21, 8'h00);
    wr(6'h20, 8'h40);
    v = 8'h00;
    repeat (24) begin
      @(posedge clk_in);
      #1;
      v = v | {7'h00, irq_out};
    end
    chk_byte(v, 8'h00);
    rd(6'h20, v); chk_byte(v, 8'h40);
    // First waveform shape gives no frame flag
    wr(6'h01, 8'h00);
    wr(6'h20, 8'h40);
    repeat (24) @(posedge clk_in);
    rd(6'h20, v); chk_byte(v, 8'h00);
    // Static drive gives no frame flag either
    wr(6'h01, 8'h80);
    wr(6'h00, 8'h80);
    wr(6'h20, 8'h40);
    repeat (24) @(posedge clk_in);
    rd(6'h20, v); chk_byte(v, 8'h00);
    // Source one idles without its ticks and runs with them
    wr(6'h00, 8'h85);
    @(posedge clk_in);
    #1;
    v = frames[7:0];
    repeat (20) @(posedge clk_in);
    chk_byte(frames[7:0], v);
    timing_tick_in <= 3'h1;
    repeat (20) @(posedge clk_in);
    #1;
    chk_bit(frames[7:0] != v, 1'b1);
    @(posedge clk_in);
    timing_tick_in <= 3'h0;
    wr(6'h00, 8'hC1);
    @(posedge clk_in);
    sleep_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_bit(drive_min_out, 1'b1);
    chk_bit(prescale_out.module_active, 1'b0);
    v = frames[7:0];
    repeat (20) @(posedge clk_in);
    chk_byte(frames[7:0], v);
    sleep_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk_bit(drive_min_out, 1'b0);
    // System clock source stops on sleep even with the sleep bit clear
    wr(6'h00, 8'h81);
    @(posedge clk_in);
    sleep_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_bit(drive_min_out, 1'b1);
    chk_bit(prescale_out.module_active, 1'b0);
    @(posedge clk_in);
    sleep_in <= 1'b0;
    finish_test();
  end
endmodule // segment_lcd_config_regs_tb_top
